//--- src/plsl_pkg.sv
/*
 Constants, field layouts and carrier types for the serial-latch PLL
 digital section. Assumes a 200 MHz system clock and a separate serial
 clock from the host.
*/
// Functional notes
// - One serial data bit enters the 24-bit shift register per rising serial clock.
// - Words arrive MSB first; the last two bits land in DB1 and DB0.
// - Rising load strobe copies the shift register into one of four latches; code 11 also loads the function latch.
// - The destination latch comes from shift register bits DB1 and DB0.
// - Codes 00 reference, 01 feedback, 10 function, 11 initialization latch.
// - Reference divider value is 14 bits at DB15..DB2, LSB at DB2.
// - Antibacklash DB17..16, test DB19..18, lock precision DB20; DB23..21 ignored.
// - Feedback ratio 13 bits at DB20..DB8, pump gain DB21; rest ignored.
// - Function and initialization latches share one field layout, DB21..DB2.
// - Three output-select bits of the function latch steer the mux pin.
// - Digital lock indication on the mux pin is active high.
// - Precision 0: lock after three consecutive comparisons with error under 15 ns.
// - Precision 1: lock needs five consecutive comparisons under 15 ns.
// - Lock holds until any later comparison shows error above 25 ns; the code also clears lock on power-down.
// - Analog lock open-drain output is released, pulsing low at each comparison.
// - Phase detector compares divided edges, pulses reflect phase and frequency.
// - Feedback divider takes binary ratios 1 to 8191.
// - Reference divider takes binary ratios 1 to 16383.
// - Chip enable low powers down and three-states pump; high powers up per bit.
package plsl_pkg;

    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam int REF_RATIO_W = 14;
    localparam int FB_RATIO_W = 13;
    localparam int OUT_SEL_W = 3;
    localparam int ABL_W = 2;

    // Field window DB21..DB2 of every word
    localparam int FIELD_HI = 21;
    localparam int FIELD_LO = 2;
    localparam int FIELD_W = FIELD_HI - FIELD_LO + 1;

    typedef enum logic [SEL_W-1:0] {
        PLSL_SEL_REF = 2'h0,
        PLSL_SEL_FB = 2'h1,
        PLSL_SEL_FUNC = 2'h2,
        PLSL_SEL_INIT = 2'h3
    } plsl_sel_t;

    // DB21..DB2 of the reference latch, DB21 unused
    typedef struct packed {
        logic unused_hi;
        logic lock_precision_bit;
        logic [1:0] test_sel;
        logic [ABL_W-1:0] antibacklash_sel;
        logic [REF_RATIO_W-1:0] ratio;
    } plsl_ref_t;

    // DB21..DB2 of the feedback latch
    typedef struct packed {
        logic pump_gain_sel;
        logic [FB_RATIO_W-1:0] ratio;
        logic [5:0] unused_lo;
    } plsl_fb_t;

    // DB21..DB2 of the function and initialization latches
    typedef struct packed {
        logic powerdown_bit_b;
        logic [5:0] pump_current_field;
        logic [3:0] timeout_control_field;
        logic fastlock_mode_bit;
        logic fastlock_enable_bit;
        logic pump_tristate_bit;
        logic phase_polarity_bit;
        logic [OUT_SEL_W-1:0] out_sel;
        logic powerdown_bit_a;
        logic divider_reset_bit;
    } plsl_func_t;

    localparam logic [FIELD_W-1:0] LATCH_RESET = 20'h00000;

    // Output multiplexer codes
    localparam logic [OUT_SEL_W-1:0] MUX_LOW = 3'h0;
    localparam logic [OUT_SEL_W-1:0] MUX_DLOCK = 3'h1;
    localparam logic [OUT_SEL_W-1:0] MUX_FB_DIV = 3'h2;
    localparam logic [OUT_SEL_W-1:0] MUX_HIGH = 3'h3;
    localparam logic [OUT_SEL_W-1:0] MUX_REF_DIV = 3'h4;
    localparam logic [OUT_SEL_W-1:0] MUX_ALOCK = 3'h5;

    // Phase detector states, Gray along idle-lead-overlap-lag
    typedef enum logic [1:0] {
        PLSL_PD_IDLE = 2'h0,
        PLSL_PD_UP = 2'h1,
        PLSL_PD_BOTH = 2'h3,
        PLSL_PD_DN = 2'h2
    } plsl_pd_t;

    // Timing
    localparam int CLK_MHZ = 200;
    localparam int PHASE_OK_NS = 15;
    localparam int PHASE_BAD_NS = 25;
    localparam int OK_CYC = PHASE_OK_NS * CLK_MHZ / 1000;
    localparam int BAD_CYC = PHASE_BAD_NS * CLK_MHZ / 1000;
    localparam int LOCK_CNT_LO = 3;
    localparam int LOCK_CNT_HI = 5;
    localparam int ERR_W = 8;
    localparam int GOOD_W = 3;

    // Antibacklash widths in tenths of ns, rounded up to cycles
    localparam int ABL_T0 = 29;
    localparam int ABL_T1 = 13;
    localparam int ABL_T2 = 60;
    localparam int ABL_T3 = 29;
    localparam int ABL_C0 = (ABL_T0 * CLK_MHZ + 9999) / 10000;
    localparam int ABL_C1 = (ABL_T1 * CLK_MHZ + 9999) / 10000;
    localparam int ABL_C2 = (ABL_T2 * CLK_MHZ + 9999) / 10000;
    localparam int ABL_C3 = (ABL_T3 * CLK_MHZ + 9999) / 10000;
    localparam int ABL_CNT_W = 3;

    // Async input vector positions
    localparam int IN_LOAD = 0;
    localparam int IN_CE = 1;
    localparam int IN_REF = 2;
    localparam int IN_FB = 3;
    localparam int IN_N = 4;

endpackage

//--- src/plsl_divider.sv
/*
 Programmable edge divider: one output pulse for every ratio input pulses.
 Assumes edge_in is a one-cycle pulse in the clk domain.
*/
module plsl_divider #(
    parameter int WIDTH = 14
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic edge_in,
    input wire logic [WIDTH-1:0] ratio,
    output logic pulse_out
);
    logic [WIDTH-1:0] count_reg;
    logic wrap;

    // Ratio 0 behaves as 1 so the loop never stalls
    assign wrap = (count_reg >= ratio) || (ratio <= WIDTH'(1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            pulse_out <= 1'b0;
        end else if (clear) begin
            count_reg <= WIDTH'(1);
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= edge_in && wrap;
            if (edge_in) begin
                count_reg <= wrap ? WIDTH'(1) : count_reg + WIDTH'(1);
            end
        end
    end
endmodule

//--- src/plsl_core.sv
/*
 Serial latch loader, dividers, phase detector, lock detect and output
 multiplexer of a clock-generator PLL. Assumes the host holds the serial
 clock still from the last data bit until the load strobe has been high
 for at least three clk cycles, so the shift word is static when sampled.
*/
module plsl_core #(
    parameter int REF_W = plsl_pkg::REF_RATIO_W,
    parameter int FB_W = plsl_pkg::FB_RATIO_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic ref_in,
    input wire logic fb_in,
    output logic pump_up,
    output logic pump_dn,
    output logic pump_oe,
    output logic mux_output_pin,
    output logic mux_output_oe,
    output logic digital_lock,
    output logic powered_up,
    output logic pump_gain_sel,
    output logic [5:0] pump_current_field,
    output logic [3:0] timeout_control_field,
    output logic fastlock_enable_bit,
    output logic fastlock_mode_bit,
    output logic [1:0] test_sel
);
    import plsl_pkg::*;

    // Serial clock domain
    logic [WORD_W-1:0] shift_reg;

    // Clock domain
    logic [IN_N-1:0] async_in;
    logic [IN_N-1:0] meta_reg;
    logic [IN_N-1:0] sync_reg;
    logic [IN_N-1:0] prev_reg;
    logic load_rise;
    logic ref_edge;
    logic fb_edge;
    plsl_sel_t word_sel;
    plsl_ref_t ref_reg;
    plsl_fb_t fb_reg;
    plsl_func_t func_reg;
    plsl_func_t init_reg;
    logic powered;
    logic div_clear;
    logic ref_div_pulse;
    logic fb_div_pulse;
    plsl_pd_t pd_reg;
    plsl_pd_t pd_next;
    logic [ABL_CNT_W-1:0] abl_cnt_reg;
    logic [ABL_CNT_W-1:0] abl_len;
    logic [ERR_W-1:0] err_reg;
    logic cmp_done;
    logic [GOOD_W-1:0] good_reg;
    logic [GOOD_W-1:0] good_need;
    logic lock_reg;
    logic up_raw;
    logic dn_raw;
    logic mux_next;
    logic mux_oe_next;

    // Shift register on the link's own clock
    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[WORD_W-2:0], serial_data};
        end
    end

    // Two-flop synchronisers for the load, chip enable, ref and fb pin inputs
    assign async_in[IN_LOAD] = load_strobe;
    assign async_in[IN_CE] = chip_enable;
    assign async_in[IN_REF] = ref_in;
    assign async_in[IN_FB] = fb_in;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign load_rise = sync_reg[IN_LOAD] && !prev_reg[IN_LOAD];
    assign ref_edge = sync_reg[IN_REF] && !prev_reg[IN_REF];
    assign fb_edge = sync_reg[IN_FB] && !prev_reg[IN_FB];

    // Word is static here: the load strobe qualifies the crossing
    assign word_sel = plsl_sel_t'(shift_reg[SEL_W-1:0]);

    // Latch loading; unaddressed latches keep their value, except the function latch, which code 11 also loads
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_reg <= plsl_ref_t'(LATCH_RESET);
        end else if (load_rise && word_sel == PLSL_SEL_REF) begin
            ref_reg <= plsl_ref_t'(shift_reg[FIELD_HI:FIELD_LO]);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fb_reg <= plsl_fb_t'(LATCH_RESET);
        end else if (load_rise && word_sel == PLSL_SEL_FB) begin
            fb_reg <= plsl_fb_t'(shift_reg[FIELD_HI:FIELD_LO]);
        end
    end

    // Initialization word also updates the function fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            func_reg <= plsl_func_t'(LATCH_RESET);
        end else if (load_rise && (word_sel == PLSL_SEL_FUNC
                || word_sel == PLSL_SEL_INIT)) begin
            func_reg <= plsl_func_t'(shift_reg[FIELD_HI:FIELD_LO]);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            init_reg <= plsl_func_t'(LATCH_RESET);
        end else if (load_rise && word_sel == PLSL_SEL_INIT) begin
            init_reg <= plsl_func_t'(shift_reg[FIELD_HI:FIELD_LO]);
        end
    end

    // Power state from pin and software bit
    assign powered = sync_reg[IN_CE] && !func_reg.powerdown_bit_a;

    // Counter reset bit and power-down both hold the dividers
    assign div_clear = !powered || func_reg.divider_reset_bit;

    plsl_divider #(
        .WIDTH(REF_W)
    ) u_ref_div (
        .clk(clk),
        .reset_n(reset_n),
        .clear(div_clear),
        .edge_in(ref_edge),
        .ratio(REF_W'(ref_reg.ratio)),
        .pulse_out(ref_div_pulse)
    );

    plsl_divider #(
        .WIDTH(FB_W)
    ) u_fb_div (
        .clk(clk),
        .reset_n(reset_n),
        .clear(div_clear),
        .edge_in(fb_edge),
        .ratio(FB_W'(fb_reg.ratio)),
        .pulse_out(fb_div_pulse)
    );

    // Antibacklash overlap length from the reference latch
    always_comb begin
        unique case (ref_reg.antibacklash_sel)
            2'h0: abl_len = ABL_CNT_W'(ABL_C0);
            2'h1: abl_len = ABL_CNT_W'(ABL_C1);
            2'h2: abl_len = ABL_CNT_W'(ABL_C2);
            2'h3: abl_len = ABL_CNT_W'(ABL_C3);
        endcase
    end

    // Phase-frequency detector: first edge opens a pulse, second closes it
    always_comb begin
        pd_next = pd_reg;
        unique case (pd_reg)
            PLSL_PD_IDLE: begin
                if (ref_div_pulse && fb_div_pulse) begin
                    pd_next = PLSL_PD_BOTH;
                end else if (ref_div_pulse) begin
                    pd_next = PLSL_PD_UP;
                end else if (fb_div_pulse) begin
                    pd_next = PLSL_PD_DN;
                end
            end
            PLSL_PD_UP: begin
                if (fb_div_pulse) begin
                    pd_next = PLSL_PD_BOTH;
                end
            end
            PLSL_PD_DN: begin
                if (ref_div_pulse) begin
                    pd_next = PLSL_PD_BOTH;
                end
            end
            PLSL_PD_BOTH: begin
                if (abl_cnt_reg >= abl_len) begin
                    pd_next = PLSL_PD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pd_reg <= PLSL_PD_IDLE;
        end else if (div_clear) begin
            pd_reg <= PLSL_PD_IDLE;
        end else begin
            pd_reg <= pd_next;
        end
    end

    // Overlap counter keeps the dead zone out of the transfer curve
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            abl_cnt_reg <= '0;
        end else if (pd_next == PLSL_PD_BOTH && pd_reg != PLSL_PD_BOTH) begin
            abl_cnt_reg <= ABL_CNT_W'(1);
        end else if (pd_reg == PLSL_PD_BOTH) begin
            abl_cnt_reg <= abl_cnt_reg + ABL_CNT_W'(1);
        end
    end

    // Phase error width in cycles, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_reg <= '0;
        end else if (pd_reg == PLSL_PD_IDLE) begin
            err_reg <= '0;
        end else if ((pd_reg == PLSL_PD_UP || pd_reg == PLSL_PD_DN)
                && err_reg != '1) begin
            err_reg <= err_reg + ERR_W'(1);
        end
    end

    // One comparison finishes as the overlap begins
    assign cmp_done = pd_next == PLSL_PD_BOTH && pd_reg != PLSL_PD_BOTH;

    assign good_need = ref_reg.lock_precision_bit
        ? GOOD_W'(LOCK_CNT_HI) : GOOD_W'(LOCK_CNT_LO);

    // Digital lock detector
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            good_reg <= '0;
            lock_reg <= 1'b0;
        end else if (!powered) begin
            good_reg <= '0;
            lock_reg <= 1'b0;
        end else if (cmp_done) begin
            if (err_reg < ERR_W'(OK_CYC)) begin
                if (good_reg < good_need) begin
                    good_reg <= good_reg + GOOD_W'(1);
                end
                if (good_reg + GOOD_W'(1) >= good_need) begin
                    lock_reg <= 1'b1;
                end
            end else if (err_reg > ERR_W'(BAD_CYC)) begin
                good_reg <= '0;
                lock_reg <= 1'b0;
            end else begin
                // Mid-band error breaks the run but keeps lock
                good_reg <= '0;
            end
        end
    end

    // Pump drive with polarity swap; 1 means positive slope
    assign up_raw = pd_reg == PLSL_PD_UP || pd_reg == PLSL_PD_BOTH;
    assign dn_raw = pd_reg == PLSL_PD_DN || pd_reg == PLSL_PD_BOTH;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pump_up <= 1'b0;
            pump_dn <= 1'b0;
            pump_oe <= 1'b0;
        end else begin
            pump_up <= func_reg.phase_polarity_bit ? up_raw : dn_raw;
            pump_dn <= func_reg.phase_polarity_bit ? dn_raw : up_raw;
            pump_oe <= powered && !func_reg.pump_tristate_bit;
        end
    end

    // Output multiplexer
    always_comb begin
        mux_next = 1'b0;
        mux_oe_next = 1'b1;
        case (func_reg.out_sel)
            MUX_DLOCK: mux_next = lock_reg;
            MUX_FB_DIV: mux_next = fb_div_pulse;
            MUX_HIGH: mux_next = 1'b1;
            MUX_REF_DIV: mux_next = ref_div_pulse;
            MUX_ALOCK: begin
                // Open drain: pulls low only while a pump pulse is open
                mux_next = 1'b0;
                mux_oe_next = up_raw || dn_raw;
            end
            default: mux_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mux_output_pin <= 1'b0;
            mux_output_oe <= 1'b0;
        end else begin
            mux_output_pin <= mux_next;
            mux_output_oe <= mux_oe_next;
        end
    end

    // Status and static control outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            digital_lock <= 1'b0;
            powered_up <= 1'b0;
            pump_gain_sel <= 1'b0;
            pump_current_field <= '0;
            timeout_control_field <= '0;
            fastlock_enable_bit <= 1'b0;
            fastlock_mode_bit <= 1'b0;
            test_sel <= '0;
        end else begin
            digital_lock <= lock_reg;
            powered_up <= powered;
            pump_gain_sel <= fb_reg.pump_gain_sel;
            pump_current_field <= func_reg.pump_current_field;
            timeout_control_field <= func_reg.timeout_control_field;
            fastlock_enable_bit <= func_reg.fastlock_enable_bit;
            fastlock_mode_bit <= func_reg.fastlock_mode_bit;
            test_sel <= ref_reg.test_sel;
        end
    end
endmodule

//--- testbench/plsl_core_chk.sv
/*
 Pin-level assertions for plsl_core, attached by bind.
 Assumes every check lives in the clk domain; serial pins are not watched.
*/
module plsl_core_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic ref_in,
    input wire logic fb_in,
    input wire logic pump_up,
    input wire logic pump_dn,
    input wire logic pump_oe,
    input wire logic mux_output_pin,
    input wire logic mux_output_oe,
    input wire logic digital_lock,
    input wire logic powered_up,
    input wire logic pump_gain_sel,
    input wire logic [5:0] pump_current_field,
    input wire logic [3:0] timeout_control_field,
    input wire logic fastlock_enable_bit,
    input wire logic fastlock_mode_bit,
    input wire logic [1:0] test_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] load_hist;

    // Window wide enough for the strobe synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            load_hist <= 6'h00;
        end else begin
            load_hist <= {load_hist[4:0], load_strobe};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_ce_off;
        !chip_enable [*5] |-> !pump_oe && !powered_up;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("enabled while off");
    property p_pd_lock;
        !powered_up [*3] |-> !digital_lock;
    endproperty
    a_pd_lock: assert property (p_pd_lock) else $error("lock while down");
    property p_lock_rise;
        $rose(digital_lock) |-> powered_up ##[0:2] (pump_up && pump_dn);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rise");
    property p_lock_fall;
        $fell(digital_lock) && powered_up && $past(powered_up)
            |-> ##[0:2] (pump_up && pump_dn);
    endproperty
    a_lock_fall: assert property (p_lock_fall) else $error("lock fall");
    property p_overlap;
        pump_up && pump_dn |-> ##[1:2] !(pump_up || pump_dn);
    endproperty
    a_overlap: assert property (p_overlap) else $error("long overlap");
    property p_od;
        !mux_output_oe |-> !mux_output_pin;
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_fields;
        $changed({pump_gain_sel, pump_current_field, timeout_control_field,
            fastlock_enable_bit, fastlock_mode_bit, test_sel}) |-> |load_hist;
    endproperty
    a_fields: assert property (p_fields) else $error("field w/o load");
    property p_rst;
        $rose(reset_n) |-> !digital_lock && !pump_up && !pump_dn;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    c_lock: cover property ($rose(digital_lock));
    c_unlock: cover property ($fell(digital_lock) && powered_up);
    c_od: cover property (!mux_output_oe);
endmodule

bind plsl_core plsl_core_chk u_plsl_core_chk (
    .clk(clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe),
    .chip_enable(chip_enable), .ref_in(ref_in), .fb_in(fb_in),
    .pump_up(pump_up), .pump_dn(pump_dn), .pump_oe(pump_oe),
    .mux_output_pin(mux_output_pin), .mux_output_oe(mux_output_oe),
    .digital_lock(digital_lock), .powered_up(powered_up),
    .pump_gain_sel(pump_gain_sel), .pump_current_field(pump_current_field),
    .timeout_control_field(timeout_control_field),
    .fastlock_enable_bit(fastlock_enable_bit),
    .fastlock_mode_bit(fastlock_mode_bit), .test_sel(test_sel)
);

//--- testbench/plsl_host.sv
/*
 Host side of the three-wire link: shifts a word out and strobes it in.
 Assumes clk is the device system clock, used to time the load strobe.
*/
module plsl_host (
    input wire logic clk,
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    // Link clock runs only inside a frame, 6 ns period
    task automatic send(input logic [23:0] word);
        for (int i = 23; i >= 0; i--) begin
            serial_data = word[i];
            #3 serial_clk = 1'b1;
            #3 serial_clk = 1'b0;
        end
        // Released line shows the inverse, never a held bit
        serial_data = ~serial_data;
        @(negedge clk);
        load_strobe = 1'b1;
        repeat (5) @(negedge clk);
        load_strobe = 1'b0;
        repeat (5) @(negedge clk);
    endtask
endmodule

//--- testbench/test_plsl_core.sv
/*
 Self-checking bench for plsl_core: latches, mux codes, lock detect and
 power-down. Assumes plsl_host drives the serial link.
*/
module test_plsl_core;
    timeunit 1ns;
    timeprecision 100ps;
    import plsl_pkg::*;
    logic clk, reset_n, chip_enable, ref_in, fb_in, seen_up, seen_dn;
    logic serial_clk, serial_data, load_strobe;
    logic pump_up, pump_dn, pump_oe, mux_output_pin, mux_output_oe;
    logic digital_lock, powered_up, pump_gain_sel;
    logic fastlock_enable_bit, fastlock_mode_bit;
    logic [5:0] pump_current_field;
    logic [3:0] timeout_control_field;
    logic [1:0] test_sel;
    logic [2:0] codes [5] = '{MUX_LOW, MUX_HIGH, 3'h6, 3'h7, MUX_ALOCK};
    logic pins [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int n_mismatch = 0;
    int cmp_count = 0;

    plsl_core u_plsl_core (
        .clk(clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe),
        .chip_enable(chip_enable), .ref_in(ref_in), .fb_in(fb_in),
        .pump_up(pump_up), .pump_dn(pump_dn), .pump_oe(pump_oe),
        .mux_output_pin(mux_output_pin), .mux_output_oe(mux_output_oe),
        .digital_lock(digital_lock), .powered_up(powered_up),
        .pump_gain_sel(pump_gain_sel), .pump_current_field(pump_current_field),
        .timeout_control_field(timeout_control_field),
        .fastlock_enable_bit(fastlock_enable_bit),
        .fastlock_mode_bit(fastlock_mode_bit), .test_sel(test_sel)
    );
    plsl_host u_plsl_host (.clk(clk), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (pump_up === 1'b1) seen_up <= 1'b1;
        if (pump_dn === 1'b1) seen_dn <= 1'b1;
    end

    task automatic check(input string name, input logic [23:0] seen,
        input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Polarity 1 keeps ref lead on pump_up
    function automatic logic [23:0] fw(input logic [2:0] m,
        input logic [5:0] cur, input logic [3:0] tc, input logic [1:0] fl,
        input logic [1:0] sel);
        return {3'h0, cur, tc, fl, 2'h1, m, 2'h0, sel};
    endfunction

    function automatic logic [23:0] rw(input logic prec, input logic [1:0] t);
        return {3'h0, prec, t, 2'h0, 14'h0001, 2'h0};
    endfunction

    // n comparisons, each with fb trailing ref by gap cycles
    task automatic compare(input int gap, input int n);
        repeat (n) begin
            @(negedge clk);
            ref_in = 1'b1;
            repeat (gap) @(negedge clk);
            fb_in = 1'b1;
            repeat (3) @(negedge clk);
            ref_in = 1'b0;
            fb_in = 1'b0;
            repeat (12) @(negedge clk);
        end
    endtask

    // Both inputs divided by three: two pin pulses per six edges
    task automatic t_div(input logic [2:0] m);
        logic [23:0] n = '0;
        u_plsl_host.send(fw(m, 6'h00, 4'h0, 2'b00, PLSL_SEL_FUNC));
        repeat (6) begin
            ref_in = 1'b1;
            fb_in = 1'b1;
            repeat (3) @(negedge clk);
            ref_in = 1'b0;
            fb_in = 1'b0;
            repeat (3) begin
                @(negedge clk);
                n += mux_output_pin;
            end
        end
        check("divided_pulses", n, 24'h2);
    endtask

    task automatic t_latches;
        chip_enable = 1'b1;
        u_plsl_host.send(fw(MUX_HIGH, 6'h2A, 4'h9, 2'b01, PLSL_SEL_FUNC));
        check("pump_current_field", pump_current_field, 6'h2A);
        check("timeout_control_field", timeout_control_field, 4'h9);
        check("fastlock_enable_bit", fastlock_enable_bit, 1'b1);
        check("fastlock_mode_bit", fastlock_mode_bit, 1'b0);
        check("mux_output_pin", mux_output_pin, 1'b1);
        check("pump_oe", pump_oe, 1'b1);
        check("powered_up", powered_up, 1'b1);
        u_plsl_host.send({2'h0, 1'b1, 13'h0001, 6'h00, 2'h1});
        check("pump_gain_sel", pump_gain_sel, 1'b1);
        check("pump_current_field", pump_current_field, 6'h2A);
        u_plsl_host.send(rw(1'b0, 2'h2));
        check("test_sel", test_sel, 2'h2);
        check("pump_gain_sel", pump_gain_sel, 1'b1);
        u_plsl_host.send(fw(MUX_LOW, 6'h15, 4'h6, 2'b10, PLSL_SEL_INIT));
        check("pump_current_field", pump_current_field, 6'h15);
        check("fastlock_mode_bit", fastlock_mode_bit, 1'b1);
        check("mux_output_pin", mux_output_pin, 1'b0);
    endtask

    task automatic t_mux;
        for (int i = 0; i < 5; i++) begin
            u_plsl_host.send(fw(codes[i], 6'h00, 4'h0, 2'b00, PLSL_SEL_FUNC));
            check("mux_output_pin", mux_output_pin, pins[i]);
            check("mux_output_oe", mux_output_oe, codes[i] != MUX_ALOCK);
        end
    endtask

    task automatic t_lock;
        u_plsl_host.send(fw(MUX_DLOCK, 6'h00, 4'h0, 2'b00, PLSL_SEL_FUNC));
        compare(1, 2);
        check("digital_lock", digital_lock, 1'b0);
        compare(1, 1);
        check("digital_lock", digital_lock, 1'b1);
        check("mux_output_pin", mux_output_pin, 1'b1);
        check("seen_up", seen_up, 1'b1);
        check("seen_dn", seen_dn, 1'b1);
        compare(4, 1);
        check("digital_lock", digital_lock, 1'b1);
        compare(8, 1);
        check("digital_lock", digital_lock, 1'b0);
        u_plsl_host.send(rw(1'b1, 2'h0));
        compare(1, 4);
        check("digital_lock", digital_lock, 1'b0);
        compare(1, 1);
        check("digital_lock", digital_lock, 1'b1);
        chip_enable = 1'b0;
        repeat (6) @(negedge clk);
        check("digital_lock", digital_lock, 1'b0);
        check("pump_oe", pump_oe, 1'b0);
        check("powered_up", powered_up, 1'b0);
    endtask

    initial begin
        reset_n = 1'b0;
        chip_enable = 1'b0;
        ref_in = 1'b0;
        fb_in = 1'b0;
        seen_up = 1'b0;
        seen_dn = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        check("digital_lock", digital_lock, 1'b0);
        check("powered_up", powered_up, 1'b0);
        check("pump_current_field", pump_current_field, 6'h00);
        t_latches();
        t_mux();
        u_plsl_host.send({8'h00, 14'h0003, 2'h0});
        u_plsl_host.send({3'h0, 13'h0003, 8'h01});
        t_div(MUX_REF_DIV);
        t_div(MUX_FB_DIV);
        // Power cycle drops the lock run built up above
        chip_enable = 1'b0;
        repeat (4) @(negedge clk);
        chip_enable = 1'b1;
        u_plsl_host.send(rw(1'b0, 2'h2));
        u_plsl_host.send({3'h0, 13'h0001, 8'h01});
        t_lock();
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule
